// ---- design/rx_poll_pkg.sv ----
// Purpose: shared constants and types for the receive polling sequencer
// Assumes: ticks arrive as one-cycle pulses on clock_in
// Notes: phase codes are what the phase output shows
package rx_poll_pkg;
  localparam int SLEEP_W = 5;
  localparam int LIM_W = 6;
  localparam int BITSEL_W = 2;
  localparam int SLEEP_UNIT_SHIFT = 10;
  localparam int SLEEP_EXT_SHIFT = 3;
  localparam int SLEEP_CNT_W = SLEEP_W + SLEEP_UNIT_SHIFT + SLEEP_EXT_SHIFT;
  localparam int CHECKS_PER_BIT = 2;
  localparam int BITS_PER_STEP = 3;
  localparam int CHECK_CNT_W = 5;
  localparam int SYNC_STAGES = 3;
  localparam int PHASE_W = 3;
  localparam logic [PHASE_W-1:0] PHASE_OFF = 3'h0;
  localparam logic [PHASE_W-1:0] PHASE_SLEEP = 3'h1;
  localparam logic [PHASE_W-1:0] PHASE_STARTUP_SYNTH = 3'h2;
  localparam logic [PHASE_W-1:0] PHASE_STARTUP_SIG = 3'h3;
  localparam logic [PHASE_W-1:0] PHASE_BIT_CHECK = 3'h4;
  localparam logic [PHASE_W-1:0] PHASE_RECEIVING = 3'h5;
  typedef enum logic [PHASE_W-1:0] {
    ST_OFF,
    ST_SLEEP,
    ST_STARTUP_SYNTH,
    ST_STARTUP_SIG,
    ST_BIT_CHECK,
    ST_RECEIVING
  } poll_state_t;
endpackage

// ---- design/rx_polling_bit_check.sv ----
// Purpose: receive polling sequencer with edge-interval bit check
// Assumes: base and bit-check ticks are same-clock pulses; lock, ready and demod are async
// Notes: receiving-mode buffering is outside this block
// Behaviour
// - sleep lasts sleep field times 1024 base ticks times extension factor.
// - extension bit 0 gives factor 1, bit 1 gives factor 8.
// - start-up enables synthesizer, then signal processing after lock, then ready.
// - bit check measures each edge-to-edge interval against a window.
// - two passed interval checks make one verified bit.
// - bit-count select gives 0, 3, 6 or 9 bits, i.e. 0/6/12/18 checks.
// - after the programmed checks pass, switch to receiving mode.
// - interval inside the window continues the check with the next interval.
// - interval outside the window aborts the check and returns to sleep in polling mode.
// - lower limit is low value ticks, upper limit high value minus one ticks.
// - low and high limits come from six-bit control fields.
// - interval counter advances once per bit-check tick during the check.
// - edge after the first while counter is below low limit fails the check.
// - counter reaching high limit fails the check without waiting further.
// - demodulator output is ignored during both start-up periods.
// - with no valid signal the check ends at the first failing interval.
// - polling mode cycles sleep, start-up and bit check until a check passes.
// - receiver-active output is high in start-up, bit check and receiving; phase output shows which phase is current.
// - mode bits 1,0 select polling, 1,1 select continuous receive.
// - continuous receive keeps path enabled and bit-checks without sleep.
module rx_polling_bit_check
  import rx_poll_pkg::*;
(
  // clock and reset
  input wire logic clock_in,
  input wire logic rst_in,
  // mode and configuration
  input wire logic op_mode_select_low_in,
  input wire logic op_mode_select_high_in,
  input wire logic [SLEEP_W-1:0] sleep_time_in,
  input wire logic sleep_ext_in,
  input wire logic [BITSEL_W-1:0] bit_count_sel_in,
  input wire logic [LIM_W-1:0] lim_min_in,
  input wire logic [LIM_W-1:0] lim_max_in,
  // ticks
  input wire logic base_tick_in,
  input wire logic bit_check_tick_in,
  // analog status and data
  input wire logic synth_lock_in,
  input wire logic sig_proc_ready_in,
  input wire logic demod_data_in,
  // control and status
  output logic synth_enable_out,
  output logic sig_proc_enable_out,
  output logic rx_active_out,
  output logic receiving_out,
  output logic [PHASE_W-1:0] phase_out,
  output logic check_fail_out
);

  poll_state_t state_q, state_d;
  logic [SYNC_STAGES-1:0] lock_sync_q, ready_sync_q, demod_sync_q;
  logic lock_q, ready_q, demod_q, demod_prev_q;
  logic [SLEEP_CNT_W-1:0] sleep_cnt_q, sleep_target;
  logic [LIM_W-1:0] interval_counter_q;
  logic [CHECK_CNT_W-1:0] pass_cnt_q, checks_needed;
  logic first_edge_seen_q;
  logic polling_mode, continuous_mode, edge_seen;
  logic check_fail, check_pass, all_passed;

  // three-stage synchronisers; a change counts once stages two and three agree
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      lock_sync_q <= '0;
    end else begin
      lock_sync_q <= {lock_sync_q[SYNC_STAGES-2:0], synth_lock_in};
    end
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      ready_sync_q <= '0;
    end else begin
      ready_sync_q <= {ready_sync_q[SYNC_STAGES-2:0], sig_proc_ready_in};
    end
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      demod_sync_q <= '0;
    end else begin
      demod_sync_q <= {demod_sync_q[SYNC_STAGES-2:0], demod_data_in};
    end
  end

  // a one-cycle glitch between stages two and three never reaches the state machine
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      lock_q <= 1'b0;
    end else if (lock_sync_q[1] == lock_sync_q[2]) begin
      lock_q <= lock_sync_q[2];
    end
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      ready_q <= 1'b0;
    end else if (ready_sync_q[1] == ready_sync_q[2]) begin
      ready_q <= ready_sync_q[2];
    end
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      demod_q <= 1'b0;
    end else if (demod_sync_q[1] == demod_sync_q[2]) begin
      demod_q <= demod_sync_q[2];
    end
  end

  // reset level matches the idle level of demod_q, so no false edge follows reset
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      demod_prev_q <= 1'b0;
    end else begin
      demod_prev_q <= demod_q;
    end
  end

  assign polling_mode = op_mode_select_high_in && !op_mode_select_low_in;
  assign continuous_mode = op_mode_select_high_in && op_mode_select_low_in;

  // shifts stand in for the 1024 and 8 multipliers
  always_comb begin
    sleep_target = {{(SLEEP_CNT_W-SLEEP_W){1'b0}}, sleep_time_in} << SLEEP_UNIT_SHIFT;
    if (sleep_ext_in) begin
      sleep_target = sleep_target << SLEEP_EXT_SHIFT;
    end
  end

  // 0/3/6/9 bits, two interval checks per bit
  assign checks_needed = CHECK_CNT_W'(int'(bit_count_sel_in) * BITS_PER_STEP
                                      * CHECKS_PER_BIT);

  // edges outside the bit check never reach the window logic
  assign edge_seen = (state_q == ST_BIT_CHECK) && (demod_q != demod_prev_q);

  always_comb begin
    check_fail = 1'b0;
    check_pass = 1'b0;
    if (state_q == ST_BIT_CHECK) begin
      if (interval_counter_q >= lim_max_in) begin
        check_fail = 1'b1;
      end else if (edge_seen && first_edge_seen_q) begin
        if (interval_counter_q < lim_min_in) begin
          check_fail = 1'b1;
        end else begin
          check_pass = 1'b1;
        end
      end
    end
  end

  assign all_passed = (pass_cnt_q >= checks_needed) ||
                      (check_pass && (pass_cnt_q + 1'b1 >= checks_needed));

  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_OFF: begin
        if (polling_mode) begin
          state_d = ST_SLEEP;
        end else if (continuous_mode) begin
          state_d = ST_STARTUP_SYNTH;
        end
      end
      ST_SLEEP: begin
        if (continuous_mode || sleep_cnt_q >= sleep_target) begin
          state_d = ST_STARTUP_SYNTH;
        end
      end
      ST_STARTUP_SYNTH: begin
        if (lock_q) begin
          state_d = ST_STARTUP_SIG;
        end
      end
      ST_STARTUP_SIG: begin
        if (ready_q) begin
          state_d = ST_BIT_CHECK;
        end
      end
      ST_BIT_CHECK: begin
        if (all_passed) begin
          state_d = ST_RECEIVING;
        end else if (check_fail) begin
          // first failure ends the check whatever the bit count
          state_d = continuous_mode ? ST_BIT_CHECK : ST_SLEEP;
        end
      end
      ST_RECEIVING: begin
        state_d = ST_RECEIVING;
      end
      default: begin
        state_d = ST_OFF;
      end
    endcase
    if (!polling_mode && !continuous_mode) begin
      state_d = ST_OFF;
    end
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      state_q <= ST_OFF;
    end else begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      sleep_cnt_q <= '0;
    end else if (state_q != ST_SLEEP) begin
      sleep_cnt_q <= '0;
    end else if (base_tick_in && sleep_cnt_q < sleep_target) begin
      sleep_cnt_q <= sleep_cnt_q + 1'b1;
    end
  end

  // a restart in continuous mode also clears, since a failure re-enters the check
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      interval_counter_q <= '0;
    end else if (state_q != ST_BIT_CHECK || check_fail) begin
      interval_counter_q <= '0;
    end else if (edge_seen) begin
      interval_counter_q <= '0;
    end else if (bit_check_tick_in && interval_counter_q < lim_max_in) begin
      interval_counter_q <= interval_counter_q + 1'b1;
    end
  end

  // the first edge of a check only starts timing, since the phase before it is unknown
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      first_edge_seen_q <= 1'b0;
    end else if (state_q != ST_BIT_CHECK || check_fail) begin
      first_edge_seen_q <= 1'b0;
    end else if (edge_seen) begin
      first_edge_seen_q <= 1'b1;
    end
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      pass_cnt_q <= '0;
    end else if (state_q != ST_BIT_CHECK || check_fail) begin
      pass_cnt_q <= '0;
    end else if (check_pass) begin
      pass_cnt_q <= pass_cnt_q + 1'b1;
    end
  end

  // outputs follow the next state so they change with the state register itself
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      synth_enable_out <= 1'b0;
    end else begin
      synth_enable_out <= (state_d != ST_OFF) && (state_d != ST_SLEEP);
    end
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      sig_proc_enable_out <= 1'b0;
    end else begin
      sig_proc_enable_out <= (state_d == ST_STARTUP_SIG) || (state_d == ST_BIT_CHECK) ||
                             (state_d == ST_RECEIVING);
    end
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      rx_active_out <= 1'b0;
    end else begin
      rx_active_out <= (state_d != ST_OFF) && (state_d != ST_SLEEP);
    end
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      receiving_out <= 1'b0;
    end else begin
      receiving_out <= (state_d == ST_RECEIVING);
    end
  end

  // a failure once the programmed checks have all passed is not reported
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      check_fail_out <= 1'b0;
    end else begin
      check_fail_out <= check_fail && !all_passed;
    end
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      phase_out <= PHASE_OFF;
    end else begin
      case (state_d)
        ST_SLEEP: phase_out <= PHASE_SLEEP;
        ST_STARTUP_SYNTH: phase_out <= PHASE_STARTUP_SYNTH;
        ST_STARTUP_SIG: phase_out <= PHASE_STARTUP_SIG;
        ST_BIT_CHECK: phase_out <= PHASE_BIT_CHECK;
        ST_RECEIVING: phase_out <= PHASE_RECEIVING;
        default: phase_out <= PHASE_OFF;
      endcase
    end
  end

endmodule

// ---- test/rx_polling_bit_check_sva.sv ----
// Purpose: port checker for the polling sequencer
// Assumes: front end drops lock and ready when disabled
// Notes: sync delay is allowed for by five-cycle runs
module rx_polling_bit_check_sva
  import rx_poll_pkg::*;
(
  // clock, reset, inputs
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic op_mode_select_low_in,
  input wire logic op_mode_select_high_in,
  input wire logic synth_lock_in,
  input wire logic sig_proc_ready_in,
  // outputs
  input wire logic synth_enable_out,
  input wire logic sig_proc_enable_out,
  input wire logic rx_active_out,
  input wire logic receiving_out,
  input wire logic [PHASE_W-1:0] phase_out,
  input wire logic check_fail_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clock_in); endclocking
  default disable iff (rst_in);
  chk_sleep_quiet: assert property (phase_out == PHASE_SLEEP |-> !rx_active_out)
    else $error("active while asleep");
  chk_synth_first: assert property (phase_out == PHASE_STARTUP_SYNTH |->
    synth_enable_out && !sig_proc_enable_out)
    else $error("start-up order wrong");
  chk_lock_gate: assert property ((phase_out == PHASE_STARTUP_SYNTH && !synth_lock_in) [*5]
    |=> phase_out != PHASE_STARTUP_SIG)
    else $error("left synth start-up without lock");
  chk_ready_gate: assert property ((phase_out == PHASE_STARTUP_SIG && !sig_proc_ready_in) [*5]
    |=> phase_out != PHASE_BIT_CHECK)
    else $error("check began before ready");
  chk_recv_flags: assert property (receiving_out |-> phase_out == PHASE_RECEIVING && rx_active_out)
    else $error("receiving flags disagree");
  chk_recv_hold: assert property (receiving_out && op_mode_select_high_in |=> receiving_out)
    else $error("receiving dropped");
  chk_fail_sleep: assert property (check_fail_out && !op_mode_select_low_in |->
    phase_out == PHASE_SLEEP && !synth_enable_out)
    else $error("failed check not asleep");
  chk_fail_from: assert property ($rose(check_fail_out) |->
    $past(phase_out) == PHASE_BIT_CHECK ##1 !check_fail_out)
    else $error("bad fail pulse");
  chk_mode_off: assert property (!op_mode_select_high_in |=> phase_out == PHASE_OFF)
    else $error("not off");
  chk_cont_nosleep: assert property (op_mode_select_high_in && op_mode_select_low_in
    |=> phase_out != PHASE_SLEEP)
    else $error("slept in continuous mode");
  cover property (receiving_out);
  cover property ($rose(check_fail_out));
  cover property (phase_out == PHASE_STARTUP_SIG);
endmodule
bind rx_polling_bit_check rx_polling_bit_check_sva chk (.clock_in, .rst_in,
  .op_mode_select_low_in, .op_mode_select_high_in, .synth_lock_in, .sig_proc_ready_in,
  .synth_enable_out, .sig_proc_enable_out, .rx_active_out, .receiving_out, .phase_out,
  .check_fail_out);

// ---- test/rx_front_model.sv ----
// Purpose: front end and remote transmitter model
// Assumes: half_in of zero means no carrier edges
// Notes: lock and ready fall as soon as their enable falls
module rx_front_model (
  // clock, control from the sequencer, half period from the bench
  input wire logic clock_in,
  input wire logic synth_enable_in,
  input wire logic sig_proc_enable_in,
  input wire logic [7:0] half_in,
  // lines into the sequencer
  output logic synth_lock_out,
  output logic sig_proc_ready_out,
  output logic demod_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] run_q = 8'h00;
  logic [7:0] lock_q = 8'h00;
  logic [7:0] rdy_q = 8'h00;
  logic demod_q = 1'b0;
  always_ff @(posedge clock_in) lock_q <= !synth_enable_in ? 8'h00 : lock_q + 8'(lock_q != 8'h14);
  always_ff @(posedge clock_in) rdy_q <= !sig_proc_enable_in ? 8'h00 : rdy_q + 8'(rdy_q != 8'h08);
  always_ff @(posedge clock_in) begin
    run_q <= (run_q + 8'h01 >= half_in) ? 8'h00 : run_q + 8'h01;
    if (half_in != 8'h00 && run_q + 8'h01 >= half_in) demod_q <= !demod_q;
  end
  assign synth_lock_out = lock_q == 8'h14;
  assign sig_proc_ready_out = rdy_q == 8'h08;
  assign demod_out = demod_q;
endmodule

// ---- test/rx_polling_bit_check_tb_top.sv ----
// Purpose: self-checking bench for the polling sequencer
// Assumes: both ticks every cycle, so counts are in clock cycles
// Notes: limits 10 and 40 keep test intervals clear of the window edges
module rx_polling_bit_check_tb_top
  import rx_poll_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  `define CMP(a, b) begin checks++; if ((a) !== (b)) begin errors++; \
    $display("[ERR] %0t got %0h exp %0h", $time, a, b); end end
  logic clock_in = 1'b0, rst_in = 1'b1, mlo = 1'b0, mhi = 1'b0, ext = 1'b0;
  logic lock, rdy, dmd, syn_en, sig_en, act, rcv, fail;
  logic [4:0] slp = 5'h01;
  logic [1:0] sel = 2'h1;
  logic [7:0] half = 8'h0c;
  logic [PHASE_W-1:0] ph;
  int errors = 0, checks = 0, cycles = 0, n;
  int pass_h[2] = '{12, 30};
  int fail_h[3] = '{5, 60, 0};
  int fail_lo[3] = '{4, 38, 39};
  int fail_hi[3] = '{20, 105, 44};
  initial forever #4 clock_in = !clock_in;
  rx_polling_bit_check dut (.clock_in, .rst_in, .op_mode_select_low_in(mlo),
    .op_mode_select_high_in(mhi), .sleep_time_in(slp), .sleep_ext_in(ext),
    .bit_count_sel_in(sel), .lim_min_in(6'h0a), .lim_max_in(6'h28),
    .base_tick_in(1'b1), .bit_check_tick_in(1'b1), .synth_lock_in(lock),
    .sig_proc_ready_in(rdy), .demod_data_in(dmd), .synth_enable_out(syn_en),
    .sig_proc_enable_out(sig_en), .rx_active_out(act), .receiving_out(rcv),
    .phase_out(ph), .check_fail_out(fail));
  rx_front_model far (.clock_in, .synth_enable_in(syn_en), .sig_proc_enable_in(sig_en),
    .half_in(half), .synth_lock_out(lock), .sig_proc_ready_out(rdy), .demod_out(dmd));
  task automatic report_and_stop();
    if (errors == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic wait_ph(input logic [PHASE_W-1:0] p, input int lim);
    n = 0;
    while (ph !== p && n < lim) begin
      @(negedge clock_in);
      n++;
    end
  endtask
  // a few idle cycles let stale synchronised lock and ready drain first
  task automatic restart(input int h, input logic [1:0] s);
    @(negedge clock_in);
    {mhi, mlo} = 2'b00;
    half = 8'(h);
    sel = s;
    repeat (4) @(negedge clock_in);
    mhi = 1'b1;
    wait_ph(PHASE_BIT_CHECK, 200);
  endtask
  always @(posedge clock_in) begin
    cycles++;
    if (cycles == 30000) begin
      errors++;
      report_and_stop();
    end
  end
  initial begin
    repeat (6) @(negedge clock_in);
    `CMP(ph, PHASE_OFF)
    rst_in = 1'b0;
    mhi = 1'b1;
    wait_ph(PHASE_SLEEP, 4);
    wait_ph(PHASE_STARTUP_SYNTH, 9000);
    `CMP(n inside {[1023:1026]}, 1'b1)
    mhi = 1'b0;
    ext = 1'b1;
    @(negedge clock_in);
    mhi = 1'b1;
    wait_ph(PHASE_SLEEP, 4);
    wait_ph(PHASE_STARTUP_SYNTH, 9000);
    `CMP(n inside {[8191:8194]}, 1'b1)
    slp = 5'h00;
    ext = 1'b0;
    foreach (pass_h[i]) for (int s = 0; s < 4; s++) begin
      restart(pass_h[i], s[1:0]);
      wait_ph(PHASE_RECEIVING, 700);
      `CMP(n + 4 >= 6 * s * pass_h[i] && n <= (6 * s + 1) * pass_h[i] + 8, 1'b1)
      `CMP(rcv, 1'b1)
      `CMP(act, 1'b1)
    end
    foreach (fail_h[i]) begin
      restart(fail_h[i], 2'h3);
      wait_ph(PHASE_SLEEP, 120);
      `CMP(n >= fail_lo[i] && n <= fail_hi[i], 1'b1)
    end
    @(negedge clock_in);
    {mhi, mlo} = 2'b00;
    half = 8'h05;
    repeat (4) @(negedge clock_in);
    {mhi, mlo} = 2'b11;
    wait_ph(PHASE_STARTUP_SYNTH, 2);
    `CMP(ph, PHASE_STARTUP_SYNTH)
    n = 0;
    while (fail !== 1'b1 && n < 300) begin
      @(negedge clock_in);
      n++;
    end
    `CMP(ph, PHASE_BIT_CHECK)
    half = 8'h0c;
    wait_ph(PHASE_RECEIVING, 300);
    `CMP(rcv, 1'b1)
    report_and_stop();
  end
endmodule
